// [src/suf_pkg.sv]
// shared constants and types for the serial port unit
package suf_pkg;
  // clock select codes, asynchronous mode
  localparam logic [1:0] SUF_CKS_INT = 2'h0; // internal, pin unused
  localparam logic [1:0] SUF_CKS_INT_OUT = 2'h1; // internal, 16x out
  localparam logic [1:0] SUF_CKS_EXT = 2'h2; // external 16x in
  localparam logic [1:0] SUF_CKS_BAD = 2'h3; // prohibited
  // fifo shape
  localparam int SUF_DATA_W = 8;
  localparam int SUF_FIFO_DEPTH = 16;
  localparam int SUF_CNT_W = 5;
  // oversampling ticks inside one bit
  localparam logic [3:0] SUF_SAMPLE_TICK = 4'h7; // eighth tick
  localparam logic [3:0] SUF_LAST_TICK = 4'hF;
  // last data bit index per length
  localparam logic [2:0] SUF_LAST_BIT8 = 3'h7;
  localparam logic [2:0] SUF_LAST_BIT7 = 3'h6;
  // values after reset
  localparam logic [7:0] SUF_DIV_RST = 8'h00;
  localparam logic [4:0] SUF_CNT_RST = 5'h00;
  localparam logic [7:0] SUF_BYTE_RST = 8'h00;
  // configuration bits driven by software
  typedef struct packed {
    logic [1:0] clk_sel;
    logic char_length_sel; // 1: seven data bits
    logic parity_enable;
    logic parity_odd;
    logic stop_two;
    logic tx_enable;
    logic rx_enable;
    logic tx_fifo_clear;
    logic rx_fifo_clear;
    logic modem_enable;
    logic tx_irq_enable;
    logic rx_irq_enable;
    logic rxerr_irq_enable;
    logic [4:0] tx_trig;
    logic [4:0] rx_trig;
    logic [4:0] rts_trig;
    logic [7:0] baud_div; // half period of 16x clock minus one
  } suf_cfg_s;
  // one receive fifo entry with its error status
  typedef struct packed {
    logic framing_fault;
    logic parity_fault;
    logic [7:0] data;
  } suf_rxent_s;
  typedef enum logic [2:0] {
    SUF_IDLE, SUF_START, SUF_DATA, SUF_PAR, SUF_STOP
  } suf_state_e;
endpackage

// [src/suf_uart.sv]
// serial port unit: fifo and asynchronous transmitter/receiver
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// generic synchronous fifo
module suf_fifo #(
  parameter int W = 8,
  parameter int D = 16,
  parameter int CW = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [CW-1:0] count
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // storage
  logic [AW-1:0] wp_r; // write pointer
  logic [AW-1:0] rp_r; // read pointer
  logic [CW-1:0] cnt_r; // fill level
  logic push;
  logic pop;
  assign in_ready = (cnt_r != CW'(D));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp_r];
  assign count = cnt_r;
  // pointers and level; clear empties without touching storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (clear) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end
  // storage write
  always_ff @(posedge clk) begin
    if (push) mem[wp_r] <= in_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RL1: clock select 01 internal out, 10 external
// RL2: line idles mark, start on low
// RL3: resync on start edge, sample tick eight
// RL4: seven/eight bits, parity option, stop count
// RL5: external clock is sixteen times bit rate
// RL6: independent tx and rx, each fifo buffered
// RL7: tx disable resets shifter, fifos kept
// RL8: software disables both before reconfiguring
// RL9: tx disable mid frame drives mark now
// RL10: software clears tx fifo before re-enable
// RL11: external clock must never stop
// RL12: fifo data starts frames back to back
// RL13: space flag when count below trigger
// RL14: software writes at most sixteen minus trigger
// RL15: start, data lsb first, parity, stop
// RL16: next byte loaded during stop bit
// RL17: clear-to-send high holds mark after frame
// RL18: only first stop bit checked
// RL19: store only if room, no overrun, break
// RL20: errors kept per entry, reception continues
// RL21: break char stored last, then blocked
// RL22: interrupt requests from flags and enables
// RL23: request-to-send low when empty, high over trigger
// RL24: overrun on full fifo, new byte lost
// RL25: overrun cleared by zero after read
// RL26: parity even/odd over data bits only
module suf_uart (
  input wire logic mclk,
  input wire logic arst_n,
  input wire suf_pkg::suf_cfg_s cfg,
  input wire logic tx_wr_valid,
  output logic tx_wr_ready,
  input wire logic [7:0] tx_wr_data,
  output logic rx_rd_valid,
  input wire logic rx_rd_ready,
  output suf_pkg::suf_rxent_s rx_rd_data,
  input wire logic overrun_read,
  input wire logic overrun_clear,
  input wire logic rx_fault_clear,
  input wire logic line_break_clear,
  output logic tx_space_flag,
  output logic tx_done_flag,
  output logic rx_fifo_trigger_flag,
  output logic rx_data_ready_flag,
  output logic rx_fault_flag,
  output logic line_break_flag,
  output logic overrun_flag,
  output logic tx_space_irq,
  output logic rx_data_irq,
  output logic rx_error_irq,
  output logic break_overrun_irq,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic rxd,
  output logic txd,
  input wire logic cts_n,
  output logic rts_n
);
  import suf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic [1:0] rst_q; // reset release pipe
  logic rst_n; // internal reset
  logic [1:0] sck_q;
  logic [1:0] rxd_q;
  logic [1:0] cts_q;
  logic sck_d_r; // previous synced sck
  logic rxd_d_r; // previous synced rxd
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) rst_q <= 2'h0;
    else rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];
  // idle levels high so no false edge after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 2'h3;
      rxd_q <= 2'h3;
      cts_q <= 2'h3;
      sck_d_r <= 1'b1;
      rxd_d_r <= 1'b1;
    end else begin
      sck_q <= {sck_q[0], sck_in};
      rxd_q <= {rxd_q[0], rxd};
      cts_q <= {cts_q[0], cts_n};
      sck_d_r <= sck_q[1];
      rxd_d_r <= rxd_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 16x tick: internal divider or external sck rising edge
  logic [7:0] div_r;
  logic sck_r; // internal 16x clock level
  logic tick; // one-cycle 16x enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= SUF_DIV_RST;
      sck_r <= 1'b1;
    end else if (div_r == cfg.baud_div) begin
      div_r <= SUF_DIV_RST;
      sck_r <= !sck_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end
  // prohibited code gives no ticks at all
  always_comb begin
    unique case (cfg.clk_sel) // RL1
      SUF_CKS_INT, SUF_CKS_INT_OUT:
        tick = (div_r == cfg.baud_div) && !sck_r;
      SUF_CKS_EXT: tick = sck_q[1] && !sck_d_r; // RL5
      SUF_CKS_BAD: tick = 1'b0;
    endcase
  end
  // clock driven out only in internal-with-output mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_out <= 1'b1;
      sck_oe <= 1'b0;
    end else begin
      sck_out <= sck_r;
      sck_oe <= (cfg.clk_sel == SUF_CKS_INT_OUT); // RL1
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fifos, one per direction
  logic tx_pop;
  logic tx_avail;
  logic [7:0] tx_head;
  logic [4:0] tx_cnt;
  logic rx_push;
  logic rx_room;
  logic [4:0] rx_cnt;
  suf_rxent_s rx_ent;
  // fifos keep contents when enables drop
  suf_fifo #(.W(SUF_DATA_W), .D(SUF_FIFO_DEPTH), .CW(SUF_CNT_W)) u_txf (
    .clk(mclk), .rst_n(rst_n), .clear(cfg.tx_fifo_clear), // RL7
    .in_valid(tx_wr_valid), .in_ready(tx_wr_ready), .in_data(tx_wr_data),
    .out_valid(tx_avail), .out_ready(tx_pop), .out_data(tx_head),
    .count(tx_cnt)
  ); // RL6
  suf_fifo #(.W($bits(suf_rxent_s)), .D(SUF_FIFO_DEPTH),
    .CW(SUF_CNT_W)) u_rxf (
    .clk(mclk), .rst_n(rst_n), .clear(cfg.rx_fifo_clear),
    .in_valid(rx_push), .in_ready(rx_room), .in_data(rx_ent),
    .out_valid(rx_rd_valid), .out_ready(rx_rd_ready),
    .out_data(rx_rd_data), .count(rx_cnt)
  ); // RL6 RL20

  ////////////////////////////////////////////////////////////////////////
  // transmitter
  suf_state_e ts_r;
  logic [3:0] tcnt_r; // tick within bit
  logic [2:0] tbit_r; // data bit index
  logic tstop2_r; // in second stop bit
  logic [7:0] tsh_r; // tx shift register
  logic tpar_r; // parity of sent frame
  logic tx_go; // clear-to-send allows a start
  logic tbit_end;
  logic tlast_stop;
  logic [2:0] last_bit;
  assign last_bit = cfg.char_length_sel ? SUF_LAST_BIT7 : SUF_LAST_BIT8;
  assign tx_go = !(cfg.modem_enable && cts_q[1]); // RL17
  assign tbit_end = tick && (tcnt_r == SUF_LAST_TICK);
  assign tlast_stop = (ts_r == SUF_STOP) && tbit_end
                      && (tstop2_r || !cfg.stop_two);
  // pop from idle, or during last stop bit for gapless frames
  assign tx_pop = cfg.tx_enable && tx_avail && tx_go
                  && (ts_r == SUF_IDLE || tlast_stop); // RL12 RL16
  // frame sequencer; disable returns at once to idle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ts_r <= SUF_IDLE;
      tcnt_r <= 4'h0;
      tbit_r <= 3'h0;
      tstop2_r <= 1'b0;
      tsh_r <= SUF_BYTE_RST;
      tpar_r <= 1'b0;
    end else if (!cfg.tx_enable) begin
      ts_r <= SUF_IDLE; // RL7 RL9
      tcnt_r <= 4'h0;
      tstop2_r <= 1'b0;
      tsh_r <= SUF_BYTE_RST;
    end else if (tx_pop) begin
      ts_r <= SUF_START; // RL12
      tcnt_r <= 4'h0;
      tbit_r <= 3'h0;
      tstop2_r <= 1'b0;
      tsh_r <= tx_head;
      tpar_r <= cfg.parity_odd; // RL26
    end else if (tick && ts_r != SUF_IDLE) begin
      tcnt_r <= tcnt_r + 4'h1;
      if (tcnt_r == SUF_LAST_TICK) begin
        unique case (ts_r) // RL15
          SUF_START: ts_r <= SUF_DATA;
          SUF_DATA: begin
            tpar_r <= tpar_r ^ tsh_r[0]; // RL26
            tsh_r <= {1'b0, tsh_r[7:1]};
            tbit_r <= tbit_r + 3'h1;
            if (tbit_r == last_bit) begin // RL4
              ts_r <= cfg.parity_enable ? SUF_PAR : SUF_STOP;
            end
          end
          SUF_PAR: ts_r <= SUF_STOP;
          SUF_STOP: begin
            if (cfg.stop_two && !tstop2_r) tstop2_r <= 1'b1; // RL4
            else ts_r <= SUF_IDLE; // RL17
          end
          default: ts_r <= SUF_IDLE;
        endcase
      end
    end
  end
  // line level per state; mark whenever not framing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) txd <= 1'b1;
    else begin
      unique case (ts_r)
        SUF_START: txd <= 1'b0; // RL15
        SUF_DATA: txd <= tsh_r[0];
        SUF_PAR: txd <= tpar_r;
        SUF_STOP: txd <= 1'b1;
        SUF_IDLE: txd <= 1'b1; // RL2 RL9
        default: txd <= 1'b1;
      endcase
    end
  end
  // done flag: set when the line goes idle with nothing queued
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tx_done_flag <= 1'b1;
    else if (tx_pop) tx_done_flag <= 1'b0;
    else if (ts_r == SUF_IDLE && !tx_avail) tx_done_flag <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver
  suf_state_e rs_r;
  logic [3:0] rcnt_r;
  logic [2:0] rbit_r;
  logic [7:0] rsh_r; // rx shift register
  logic rpar_r; // running parity of data and parity bit
  logic rsample; // centre of current bit
  logic rdone; // first stop bit sampled
  logic [7:0] rdata;
  logic rfer;
  logic rper;
  assign rsample = tick && (rcnt_r == SUF_SAMPLE_TICK); // RL3
  assign rdone = rsample && (rs_r == SUF_STOP);
  // seven-bit data sits in the upper bits of the shifter
  assign rdata = cfg.char_length_sel ? {1'b0, rsh_r[7:1]} : rsh_r;
  assign rfer = !rxd_q[1]; // RL18
  assign rper = cfg.parity_enable && (rpar_r != cfg.parity_odd); // RL26
  assign rx_ent = '{framing_fault: rfer, parity_fault: rper,
                    data: rdata}; // RL20
  // halted while overrun is pending
  assign rx_push = rdone && !overrun_flag && !line_break_flag; // RL19 RL21
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rs_r <= SUF_IDLE;
      rcnt_r <= 4'h0;
      rbit_r <= 3'h0;
      rsh_r <= SUF_BYTE_RST;
      rpar_r <= 1'b0;
    end else if (!cfg.rx_enable) begin
      rs_r <= SUF_IDLE;
    end else if (rs_r == SUF_IDLE) begin
      // falling edge restarts bit timing
      if (rxd_d_r && !rxd_q[1] && !overrun_flag) begin // RL2 RL3 RL24
        rs_r <= SUF_START;
        rcnt_r <= 4'h0;
        rbit_r <= 3'h0;
        rpar_r <= 1'b0;
      end
    end else if (tick) begin
      rcnt_r <= rcnt_r + 4'h1;
      if (rcnt_r == SUF_SAMPLE_TICK) begin
        unique case (rs_r)
          // a glitch shorter than half a bit is not a start
          SUF_START: if (rxd_q[1]) rs_r <= SUF_IDLE; else rs_r <= SUF_DATA;
          SUF_DATA: begin
            rsh_r <= {rxd_q[1], rsh_r[7:1]}; // RL15
            rpar_r <= rpar_r ^ rxd_q[1];
            rbit_r <= rbit_r + 3'h1;
            if (rbit_r == last_bit) begin // RL4
              rs_r <= cfg.parity_enable ? SUF_PAR : SUF_STOP;
            end
          end
          SUF_PAR: begin
            rpar_r <= rpar_r ^ rxd_q[1];
            rs_r <= SUF_STOP;
          end
          // second stop bit is not checked; rearm now
          SUF_STOP: rs_r <= SUF_IDLE; // RL18 RL20
          default: rs_r <= SUF_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive status flags; hardware set wins over clear
  logic ovr_seen_r; // overrun read as one since set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_flag <= 1'b0;
      ovr_seen_r <= 1'b0;
    end else if (rdone && !rx_room && !line_break_flag) begin
      overrun_flag <= 1'b1; // RL24
    end else if (overrun_clear && ovr_seen_r) begin
      overrun_flag <= 1'b0; // RL25
      ovr_seen_r <= 1'b0;
    end else if (overrun_read && overrun_flag) begin
      ovr_seen_r <= 1'b1; // RL25
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rx_fault_flag <= 1'b0;
    else if (rdone && (rfer || rper)) rx_fault_flag <= 1'b1; // RL20
    else if (rx_fault_clear) rx_fault_flag <= 1'b0;
  end
  // break: all-zero character with framing fault
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) line_break_flag <= 1'b0;
    else if (rdone && rfer && rdata == SUF_BYTE_RST) begin
      line_break_flag <= 1'b1; // RL21
    end else if (line_break_clear) line_break_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // level flags, interrupt requests and modem control
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_space_flag <= 1'b1;
      rx_fifo_trigger_flag <= 1'b0;
      rx_data_ready_flag <= 1'b0;
      tx_space_irq <= 1'b0;
      rx_data_irq <= 1'b0;
      rx_error_irq <= 1'b0;
      break_overrun_irq <= 1'b0;
    end else begin
      tx_space_flag <= (tx_cnt < cfg.tx_trig); // RL13
      rx_fifo_trigger_flag <= (rx_cnt >= cfg.rx_trig);
      rx_data_ready_flag <= (rx_cnt != SUF_CNT_RST)
                            && (rx_cnt < cfg.rx_trig);
      tx_space_irq <= tx_space_flag && cfg.tx_irq_enable; // RL13
      rx_data_irq <= (rx_fifo_trigger_flag || rx_data_ready_flag)
                     && cfg.rx_irq_enable; // RL22
      rx_error_irq <= rx_fault_flag
                      && (cfg.rx_irq_enable || cfg.rxerr_irq_enable);
      break_overrun_irq <= (line_break_flag || overrun_flag)
                           && (cfg.rx_irq_enable || cfg.rxerr_irq_enable);
    end
  end
  // request-to-send: low on empty, high above trigger, else held
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rts_n <= 1'b1;
    else if (!cfg.modem_enable) rts_n <= 1'b1;
    else if (rx_cnt == SUF_CNT_RST) rts_n <= 1'b0; // RL23
    else if (rx_cnt > cfg.rts_trig) rts_n <= 1'b1; // RL23
  end
endmodule

// [sim/suf_uart_properties.sv]
// port assertions for the serial port unit
`timescale 1ns/1ps
module suf_uart_properties (
  input wire logic mclk,
  input wire logic arst_n,
  input wire suf_pkg::suf_cfg_s cfg,
  input wire logic rx_rd_valid,
  input wire logic rx_rd_ready,
  input wire suf_pkg::suf_rxent_s rx_rd_data,
  input wire logic overrun_clear,
  input wire logic tx_space_flag,
  input wire logic tx_done_flag,
  input wire logic rx_fifo_trigger_flag,
  input wire logic rx_data_ready_flag,
  input wire logic line_break_flag,
  input wire logic overrun_flag,
  input wire logic rx_fault_flag,
  input wire logic tx_space_irq,
  input wire logic rx_data_irq,
  input wire logic rx_error_irq,
  input wire logic break_overrun_irq,
  input wire logic sck_oe,
  input wire logic txd,
  input wire logic rts_n
);
  import suf_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // edges since reset: $past is only trusted once the reset sync let go
  logic [2:0] up_r;
  logic live;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      up_r <= 3'h0;
    end else if (up_r != 3'h7) begin
      up_r <= up_r + 3'h1;
    end
  end
  assign live = (up_r == 3'h7);
  ////////////////////////////////////////
  sequence s_tx_off;
    !cfg.tx_enable [*4];
  endsequence
  sequence s_sel_calm;
    (live && $stable(cfg.clk_sel)) [*3];
  endsequence
  sequence s_rx_empty;
    (live && cfg.modem_enable && !rx_rd_valid) [*3];
  endsequence
  a_txd_mark_off: assert property (s_tx_off |-> txd)
    else $error("txd not at mark while off");
  a_sck_dir: assert property (s_sel_calm |->
    sck_oe == (cfg.clk_sel == SUF_CKS_INT_OUT))
    else $error("sck_oe wrong for clock select");
  a_done_mark: assert property (tx_done_flag [*2] |-> txd)
    else $error("txd low while transmitter done");
  a_tx_irq_follow: assert property (live |->
    tx_space_irq == $past(tx_space_flag && cfg.tx_irq_enable))
    else $error("tx irq mismatch");
  a_rx_irq_follow: assert property (live |->
    rx_data_irq == $past((rx_fifo_trigger_flag || rx_data_ready_flag)
    && cfg.rx_irq_enable))
    else $error("rx irq mismatch");
  a_brk_irq_follow: assert property (live |->
    break_overrun_irq == $past((line_break_flag || overrun_flag)
    && (cfg.rx_irq_enable || cfg.rxerr_irq_enable)))
    else $error("break irq mismatch");
  a_err_irq_follow: assert property (live |->
    rx_error_irq == $past(rx_fault_flag
    && (cfg.rx_irq_enable || cfg.rxerr_irq_enable)))
    else $error("error irq mismatch");
  a_rts_empty_low: assert property (s_rx_empty |-> !rts_n)
    else $error("rts_n high with empty fifo");
  a_rts_off_high: assert property (!cfg.modem_enable [*2] |-> rts_n)
    else $error("rts_n low with modem off");
  a_rx_head_hold: assert property (live && rx_rd_valid &&
    !rx_rd_ready && !cfg.rx_fifo_clear |=> $stable(rx_rd_data))
    else $error("rx head changed unread");
  a_ovr_hold: assert property (overrun_flag && !overrun_clear
    |=> overrun_flag)
    else $error("overrun flag dropped");
endmodule

bind suf_uart suf_uart_properties i_props (.mclk, .arst_n, .cfg,
  .rx_rd_valid, .rx_rd_ready, .rx_rd_data, .overrun_clear, .tx_space_flag,
  .tx_done_flag, .rx_fifo_trigger_flag, .rx_data_ready_flag,
  .line_break_flag, .overrun_flag, .rx_fault_flag, .tx_space_irq,
  .rx_data_irq, .rx_error_irq, .break_overrun_irq, .sck_oe, .txd, .rts_n);

// [sim/suf_far_end.sv]
// remote serial end: frames onto rxd, decodes txd
`timescale 1ns/1ps
module suf_far_end (
  input wire logic mclk,
  input wire logic txd,
  output logic rxd,
  input wire logic seven,
  input wire logic par_en,
  input wire logic par_odd,
  output logic [7:0] got,
  output logic got_ok,
  output logic got_stb
);
  int bit_len = 32; // mclk cycles per bit, set by the bench
  initial begin
    rxd = 1'b1;
    got_stb = 1'b0;
  end
  // one bit time; moves on falling edges, clear of sampling
  task automatic bit_wait();
    repeat (bit_len) @(negedge mclk);
  endtask
  // one frame, with optional stop or parity fault
  task automatic send(input logic [7:0] d, input logic bad_stop,
    input logic bad_par);
    logic p;
    p = par_odd ^ bad_par;
    rxd = 1'b0;
    bit_wait();
    for (int i = 0; i < (seven ? 7 : 8); i++) begin
      rxd = d[i];
      p = p ^ d[i];
      bit_wait();
    end
    if (par_en) begin
      rxd = p;
      bit_wait();
    end
    rxd = ~bad_stop;
    bit_wait();
    rxd = 1'b1; // idle gap of one bit
    bit_wait();
  endtask
  // decoder: mid-bit sampling; ok means parity and stop good
  always begin
    logic p;
    @(negedge txd);
    repeat (bit_len / 2) @(negedge mclk);
    p = par_odd;
    got = 8'h00;
    for (int i = 0; i < (seven ? 7 : 8); i++) begin
      bit_wait();
      got[i] = txd;
      p = p ^ txd;
    end
    if (par_en) begin
      bit_wait();
      p = p ^ txd;
    end else begin
      p = 1'b0;
    end
    bit_wait();
    got_ok = ~p & txd;
    got_stb = 1'b1;
    @(negedge mclk);
    got_stb = 1'b0;
  end
endmodule

// [sim/suf_uart_tb.sv]
// self-checking bench for the serial port unit
`timescale 1ns/1ps
module suf_uart_tb;
  import suf_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic sck_in = 1'b0;
  logic cts_n = 1'b0;
  logic tx_wr_valid = 1'b0;
  logic rx_rd_ready = 1'b1;
  logic [7:0] tx_wr_data = 8'h00;
  logic [2:0] pls = 3'h0; // overrun read, overrun clear, break clear
  suf_cfg_s cfg = '0;
  suf_rxent_s rx_rd_data;
  logic tx_wr_ready, rx_rd_valid, tx_space_flag, tx_done_flag;
  logic line_break_flag, overrun_flag, txd, rxd, rts_n, got_ok, got_stb;
  logic [7:0] got;
  logic [9:0] txq[$];
  logic [9:0] rxq[$];
  logic [15:0] seed = 16'h8920;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  suf_uart i_dut (.mclk, .arst_n, .cfg, .tx_wr_valid, .tx_wr_ready,
    .tx_wr_data, .rx_rd_valid, .rx_rd_ready, .rx_rd_data,
    .overrun_read(pls[0]), .overrun_clear(pls[1]), .rx_fault_clear(1'b0),
    .line_break_clear(pls[2]), .tx_space_flag, .tx_done_flag,
    .rx_fifo_trigger_flag(), .rx_data_ready_flag(), .rx_fault_flag(),
    .line_break_flag, .overrun_flag, .tx_space_irq(), .rx_data_irq(),
    .rx_error_irq(), .break_overrun_irq(), .sck_in, .sck_out(), .sck_oe(),
    .rxd, .txd, .cts_n, .rts_n);
  suf_far_end i_far (.mclk, .txd, .rxd, .seven(cfg.char_length_sel),
    .par_en(cfg.parity_enable), .par_odd(cfg.parity_odd), .got, .got_ok,
    .got_stb);
  ////////////////////////////////////////
  always #25 mclk = ~mclk;
  // external 16x clock, free running, phase unrelated to mclk
  initial begin
    #37;
    forever #100 sck_in = ~sck_in;
  end
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  function automatic logic [7:0] msk(input logic [7:0] d);
    return cfg.char_length_sel ? {1'b0, d[6:0]} : d;
  endfunction
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // tx notes against decoded frames; an unexpected frame always fails
  always @(posedge got_stb) begin
    chk({1'b0, got_ok, got}, txq.size() ? txq.pop_front() : 10'h3FF);
  end
  // rx notes against each popped head entry
  always @(posedge mclk) begin
    if (rx_rd_valid === 1'b1 && rx_rd_ready === 1'b1) begin
      chk(rx_rd_data, rxq.size() ? rxq.pop_front() : ~rx_rd_data);
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      close_out();
    end
  end
  // write one byte; leaves valid high so writes can run back to back
  task automatic put(input logic [7:0] d);
    tx_wr_valid = 1'b1;
    tx_wr_data = d;
    do @(posedge mclk); while (tx_wr_ready !== 1'b1);
    @(negedge mclk);
  endtask
  task automatic drain();
    tx_wr_valid = 1'b0;
    repeat (8) @(negedge mclk);
    while (tx_done_flag !== 1'b1) @(negedge mclk);
    repeat (4) @(negedge mclk);
  endtask
  task automatic pulse(input logic [2:0] m);
    pls = m;
    @(negedge mclk);
    pls = 3'h0;
    repeat (4) @(negedge mclk);
  endtask
  // both enables off before the format moves
  task automatic setfmt(input logic [2:0] f, input logic [1:0] sel);
    cfg.tx_enable = 1'b0;
    cfg.rx_enable = 1'b0;
    repeat (4) @(negedge mclk);
    {cfg.char_length_sel, cfg.parity_enable, cfg.stop_two} = f;
    cfg.parity_odd = ^rnd();
    cfg.clk_sel = sel;
    cfg.tx_fifo_clear = 1'b1;
    @(negedge mclk);
    cfg.tx_fifo_clear = 1'b0;
    cfg.tx_enable = 1'b1;
    cfg.rx_enable = 1'b1;
    repeat (4) @(negedge mclk);
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    logic [7:0] d;
    cfg.tx_trig = 5'h08;
    cfg.rx_trig = 5'h01;
    cfg.rts_trig = 5'h04;
    {cfg.tx_irq_enable, cfg.rx_irq_enable, cfg.rxerr_irq_enable} = 3'h7;
    repeat (10) @(negedge mclk);
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk({8'h00, txd, tx_done_flag}, 10'h003);
    // all eight formats, two frames each way
    for (int f = 0; f < 8; f++) begin
      setfmt(f[2:0], {1'b0, f[0]});
      repeat (2) begin
        d = rnd();
        txq.push_back({2'h1, msk(d)});
        put(d);
      end
      drain();
      d = rnd() | 8'h01;
      rxq.push_back({2'h0, msk(d)});
      i_far.send(d, 1'b0, 1'b0);
      d = rnd() | 8'h01;
      rxq.push_back({f == 0, cfg.parity_enable, msk(d)});
      i_far.send(d, f == 0, 1'b1);
    end
    // external 16x clock on the clock pin
    setfmt(3'h0, SUF_CKS_EXT);
    i_far.bit_len = 64;
    d = rnd();
    txq.push_back({2'h1, d});
    put(d);
    drain();
    rxq.push_back({2'h0, d});
    i_far.send(d, 1'b0, 1'b0);
    // far end holds clear-to-send off before any byte is queued, so the
    // synchronised level already blocks the first pop
    cfg.modem_enable = 1'b1;
    cts_n = 1'b1;
    setfmt(3'h0, SUF_CKS_INT);
    i_far.bit_len = 32;
    // fill all sixteen tx fifo entries, then check the write is refused
    repeat (16) begin
      d = rnd();
      txq.push_back({2'h1, d});
      put(d);
    end
    tx_wr_valid = 1'b0;
    repeat (400) @(negedge mclk);
    chk({tx_wr_ready, tx_space_flag, rts_n, 7'(txq.size())}, 10'h010);
    cts_n = 1'b0;
    drain();
    chk({9'h000, tx_space_flag}, 10'h001);
    // reader stalls: sixteen stored, seventeenth lost
    rx_rd_ready = 1'b0;
    for (int i = 0; i < 17; i++) begin
      d = rnd();
      if (i < 16) rxq.push_back({2'h0, d});
      i_far.send(d, 1'b0, 1'b0);
    end
    pulse(3'h2);
    chk({8'h00, overrun_flag, rts_n}, 10'h003);
    rx_rd_ready = 1'b1;
    repeat (40) @(negedge mclk);
    pulse(3'h1);
    pulse(3'h2);
    chk({8'h00, overrun_flag, rts_n}, 10'h000);
    // break: zero with framing fault stored last, then nothing
    rxq.push_back(10'h200);
    i_far.send(8'h00, 1'b1, 1'b0);
    i_far.send(8'h5A, 1'b0, 1'b0);
    chk({9'h000, line_break_flag}, 10'h001);
    pulse(3'h4);
    d = rnd();
    rxq.push_back({2'h0, d});
    i_far.send(d, 1'b0, 1'b0);
    chk(10'(txq.size() + rxq.size()), 10'h000);
    close_out();
  end
endmodule
